// file: rtl/clk_sel_pkg.sv
// shared constants, register map and bus carriers for the system clock selector
package clk_sel_pkg;
   // clock rates, in hertz
   localparam int unsigned CLOCK_HZ      = 125_000_000;
   localparam int unsigned FAST_OSC_HZ   = 16_000_000;
   localparam int unsigned SLOW_OSC_HZ   = 32_000;
   // phase accumulators toggle the oscillator level twice per period
   localparam logic [27:0] ACC_MOD       = 28'(CLOCK_HZ);
   localparam logic [27:0] FAST_INC      = 28'(2 * FAST_OSC_HZ);
   localparam logic [27:0] SLOW_INC      = 28'(2 * SLOW_OSC_HZ);
   localparam int unsigned FAST_HALF_CYC = CLOCK_HZ / (2 * FAST_OSC_HZ);
   localparam int unsigned SLOW_HALF_CYC = CLOCK_HZ / (2 * SLOW_OSC_HZ);
   // fast oscillator counts as settled after this many level changes
   localparam logic [4:0]  FAST_SETTLE   = 5'h10;
   // register byte offsets
   localparam logic [11:0] CLOCK_CTRL_OFS = 12'h000;
   localparam logic [11:0] FAST_OSC_OFS   = 12'h004;
   localparam logic [11:0] STATUS_OFS     = 12'h008;
   // field positions
   localparam int unsigned SEL_LSB        = 5;
   localparam int unsigned FAST_IDLE_BIT  = 1;
   localparam int unsigned SLOW_IDLE_BIT  = 0;
   localparam int unsigned FAST_EN_BIT    = 0;
   localparam int unsigned FAST_READY_BIT = 1;
   localparam int unsigned ST_SEL_LSB     = 0;
   localparam int unsigned ST_PEND_BIT    = 3;
   localparam int unsigned ST_SUB_BIT     = 4;
   // reset values and encodings
   localparam logic [2:0]  SEL_RESET      = 3'h1;
   localparam logic [2:0]  SEL_SUB        = 3'h7;
   localparam logic        IDLE_EN_RESET  = 1'h0;
   localparam logic        FAST_EN_RESET  = 1'h1;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_WAIT = 2'b01
   } switch_state_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_resp_t;
endpackage : clk_sel_pkg

// file: rtl/system_clock_select.sv
// system clock generation, division and glitch-free source selection
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module system_clock_select (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire clk_sel_pkg::axi_req_t  axi_req,
   output clk_sel_pkg::axi_resp_t      axi_resp,
   input  wire logic                  cpu_halt,
   output logic                       sys_clk,
   output logic                       fast_clk,
   output logic [6:0]                 periph_div_clk,
   output logic                       sub_clk,
   output logic                       wdt_clk
);
   // oscillator and divider state
   logic [27:0] fast_acc_reg;
   logic        fast_clk_reg;
   logic        fast_run_reg;
   logic [4:0]  fast_settle_reg;
   logic [27:0] slow_acc_reg;
   logic        slow_lvl_reg;
   logic        sub_clk_reg;
   logic        sub_run_reg;
   logic [5:0]  div_cnt_reg;
   // control and selection state
   logic [2:0]  sel_reg;
   logic        fast_idle_en_reg;
   logic        slow_idle_en_reg;
   logic        fast_osc_en_reg;
   logic [2:0]  active_sel_reg;
   logic        sys_clk_reg;
   clk_sel_pkg::switch_state_t sw_state_reg;
   clk_sel_pkg::switch_state_t sw_state_next;
   // bus slave state
   logic        aw_held_reg;
   logic [11:0] aw_addr_reg;
   logic        aw_hit_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic        w_lane0_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   // phase accumulators: a wrap flips the oscillator level
   wire  [27:0] fast_sum_w  = fast_acc_reg + clk_sel_pkg::FAST_INC;
   wire         fast_wrap_w = fast_sum_w >= clk_sel_pkg::ACC_MOD;
   wire  [27:0] fast_acc_next = fast_wrap_w ? fast_sum_w - clk_sel_pkg::ACC_MOD : fast_sum_w;
   wire  [27:0] slow_sum_w  = slow_acc_reg + clk_sel_pkg::SLOW_INC;
   wire         slow_wrap_w = slow_sum_w >= clk_sel_pkg::ACC_MOD;
   wire  [27:0] slow_acc_next = slow_wrap_w ? slow_sum_w - clk_sel_pkg::ACC_MOD : slow_sum_w;
   wire         slow_lvl_next = slow_lvl_reg ^ slow_wrap_w;
   wire         fast_rise_w = fast_run_reg & fast_wrap_w & ~fast_clk_reg;

   // oscillator run decisions; halt hands control to the idle enables
   wire         fast_needed_w = (sel_reg != clk_sel_pkg::SEL_SUB) |
                                (active_sel_reg != clk_sel_pkg::SEL_SUB) | fast_osc_en_reg;
   wire         fast_run_next = cpu_halt ? fast_idle_en_reg : fast_needed_w;
   wire         sub_run_next  = cpu_halt ? slow_idle_en_reg : 1'b1;

   // fast oscillator, stopped at a low level so a stalled source never holds a mux high
   always_ff @(posedge clock) begin
      if (!rst_n || !fast_run_reg) begin
         fast_acc_reg <= 28'h0000000;
         fast_clk_reg <= 1'b0;
      end else begin
         fast_acc_reg <= fast_acc_next;
         fast_clk_reg <= fast_clk_reg ^ fast_wrap_w;
      end
   end

   // settle count backs the ready flag after a restart
   always_ff @(posedge clock) begin
      if (!rst_n || !fast_run_reg)
         fast_settle_reg <= 5'h00;
      else if (fast_wrap_w && fast_settle_reg != clk_sel_pkg::FAST_SETTLE)
         fast_settle_reg <= fast_settle_reg + 5'h01;
   end

   // slow oscillator always runs: the watchdog depends on it even in sleep
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         slow_acc_reg <= 28'h0000000;
         slow_lvl_reg <= 1'b0;
         sub_clk_reg  <= 1'b0;
      end else begin
         slow_acc_reg <= slow_acc_next;
         slow_lvl_reg <= slow_lvl_next;
         sub_clk_reg  <= sub_run_reg & slow_lvl_next;
      end
   end

   // run flags and the ripple-free divider chain on fast rising edges
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fast_run_reg <= 1'b1;
         sub_run_reg  <= 1'b1;
         div_cnt_reg  <= 6'h00;
      end else begin
         fast_run_reg <= fast_run_next;
         sub_run_reg  <= sub_run_next;
         if (!fast_run_reg)
            div_cnt_reg <= 6'h00;
         else if (fast_rise_w)
            div_cnt_reg <= div_cnt_reg + 6'h01;
      end
   end

   // source table indexed by the selection code
   logic [7:0] src_w;
   assign src_w[0] = fast_clk_reg;
   genvar gi;
   generate
      for (gi = 1; gi < 7; gi++) begin : g_div
         assign src_w[gi] = div_cnt_reg[gi-1];
      end
   endgenerate
   assign src_w[7] = sub_clk_reg;

   // switch only while old and new sources are both low, so no pulse is cut short
   wire switch_ok_w = ~src_w[active_sel_reg] & ~src_w[sel_reg];
   always_comb begin
      sw_state_next = sw_state_reg;
      case (sw_state_reg)
         clk_sel_pkg::SW_IDLE:
            if (sel_reg != active_sel_reg)
               sw_state_next = clk_sel_pkg::SW_WAIT;
         clk_sel_pkg::SW_WAIT:
            if (switch_ok_w || sel_reg == active_sel_reg)
               sw_state_next = clk_sel_pkg::SW_IDLE;
         default:
            sw_state_next = clk_sel_pkg::SW_IDLE;
      endcase
   end
   wire switch_now_w = (sw_state_reg == clk_sel_pkg::SW_WAIT) & switch_ok_w;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sw_state_reg   <= clk_sel_pkg::SW_IDLE;
         active_sel_reg <= clk_sel_pkg::SEL_RESET;
         sys_clk_reg    <= 1'b0;
      end else begin
         sw_state_reg <= sw_state_next;
         if (switch_now_w)
            active_sel_reg <= sel_reg;
         sys_clk_reg <= src_w[active_sel_reg];
      end
   end

   // write channel: address and data taken in either order, response after both
   wire aw_fire_w  = axi_req.awvalid & ~aw_held_reg & ~bvalid_reg;
   wire w_fire_w   = axi_req.wvalid & ~w_held_reg & ~bvalid_reg;
   wire do_write_w = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire wr_ctrl_w  = do_write_w & aw_hit_reg & w_lane0_reg &
                     (aw_addr_reg == clk_sel_pkg::CLOCK_CTRL_OFS);
   wire wr_fast_w  = do_write_w & aw_hit_reg & w_lane0_reg &
                     (aw_addr_reg == clk_sel_pkg::FAST_OSC_OFS);
   wire wr_known_w = aw_hit_reg & ((aw_addr_reg == clk_sel_pkg::CLOCK_CTRL_OFS) |
                                   (aw_addr_reg == clk_sel_pkg::FAST_OSC_OFS) |
                                   (aw_addr_reg == clk_sel_pkg::STATUS_OFS));

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         aw_hit_reg  <= 1'b0;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_lane0_reg <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
      end else begin
         if (aw_fire_w) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= axi_req.awaddr[11:0];
            aw_hit_reg  <= axi_req.awaddr[31:12] == 20'h00000;
         end else if (do_write_w)
            aw_held_reg <= 1'b0;
         if (w_fire_w) begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= axi_req.wdata;
            w_lane0_reg <= axi_req.wstrb[0];
         end else if (do_write_w)
            w_held_reg <= 1'b0;
         if (do_write_w) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_known_w ? clk_sel_pkg::RESP_OKAY : clk_sel_pkg::RESP_SLVERR;
         end else if (axi_req.bready)
            bvalid_reg <= 1'b0;
      end
   end

   // software control bits; the status register is read only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sel_reg          <= clk_sel_pkg::SEL_RESET;
         fast_idle_en_reg <= clk_sel_pkg::IDLE_EN_RESET;
         slow_idle_en_reg <= clk_sel_pkg::IDLE_EN_RESET;
         fast_osc_en_reg  <= clk_sel_pkg::FAST_EN_RESET;
      end else begin
         if (wr_ctrl_w) begin
            sel_reg          <= w_data_reg[clk_sel_pkg::SEL_LSB +: 3];
            fast_idle_en_reg <= w_data_reg[clk_sel_pkg::FAST_IDLE_BIT];
            slow_idle_en_reg <= w_data_reg[clk_sel_pkg::SLOW_IDLE_BIT];
         end
         if (wr_fast_w)
            fast_osc_en_reg <= w_data_reg[clk_sel_pkg::FAST_EN_BIT];
      end
   end

   // read decode; unimplemented bits read as zero
   wire        fast_ready_w = fast_settle_reg == clk_sel_pkg::FAST_SETTLE;
   wire        pending_w    = sw_state_reg == clk_sel_pkg::SW_WAIT;
   wire [31:0] ctrl_rd_w    = (32'(sel_reg) << clk_sel_pkg::SEL_LSB) |
                              (32'(fast_idle_en_reg) << clk_sel_pkg::FAST_IDLE_BIT) |
                              (32'(slow_idle_en_reg) << clk_sel_pkg::SLOW_IDLE_BIT);
   wire [31:0] fast_rd_w    = (32'(fast_ready_w) << clk_sel_pkg::FAST_READY_BIT) |
                              (32'(fast_osc_en_reg) << clk_sel_pkg::FAST_EN_BIT);
   wire [31:0] status_rd_w  = (32'(active_sel_reg) << clk_sel_pkg::ST_SEL_LSB) |
                              (32'(pending_w) << clk_sel_pkg::ST_PEND_BIT) |
                              (32'(sub_run_reg) << clk_sel_pkg::ST_SUB_BIT);
   wire        ar_hit_w     = axi_req.araddr[31:12] == 20'h00000;
   wire [11:0] ar_ofs_w     = axi_req.araddr[11:0];
   wire        rd_ctrl_w    = ar_hit_w & (ar_ofs_w == clk_sel_pkg::CLOCK_CTRL_OFS);
   wire        rd_fast_w    = ar_hit_w & (ar_ofs_w == clk_sel_pkg::FAST_OSC_OFS);
   wire        rd_stat_w    = ar_hit_w & (ar_ofs_w == clk_sel_pkg::STATUS_OFS);
   wire [31:0] rd_data_w    = rd_ctrl_w ? ctrl_rd_w : rd_fast_w ? fast_rd_w :
                              rd_stat_w ? status_rd_w : 32'h00000000;
   wire        ar_fire_w    = axi_req.arvalid & ~rvalid_reg;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= 2'h0;
      end else if (ar_fire_w) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_data_w;
         rresp_reg  <= (rd_ctrl_w | rd_fast_w | rd_stat_w) ? clk_sel_pkg::RESP_OKAY
                                                            : clk_sel_pkg::RESP_SLVERR;
      end else if (axi_req.rready)
         rvalid_reg <= 1'b0;
   end

   // bus answers and clock outputs
   assign axi_resp.awready = ~aw_held_reg & ~bvalid_reg;
   assign axi_resp.wready  = ~w_held_reg & ~bvalid_reg;
   assign axi_resp.bvalid  = bvalid_reg;
   assign axi_resp.bresp   = bresp_reg;
   assign axi_resp.arready = ~rvalid_reg;
   assign axi_resp.rvalid  = rvalid_reg;
   assign axi_resp.rdata   = rdata_reg;
   assign axi_resp.rresp   = rresp_reg;
   assign sys_clk          = sys_clk_reg;
   assign fast_clk         = fast_clk_reg;
   assign periph_div_clk   = src_w[6:0];
   assign sub_clk          = sub_clk_reg;
   assign wdt_clk          = slow_lvl_reg;

   // checks
   localparam int FAST_LO = clk_sel_pkg::FAST_HALF_CYC;
   localparam int FAST_HI = clk_sel_pkg::FAST_HALF_CYC + 1;
   logic [11:0] slow_gap_reg;
   logic        slow_seen_reg;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         slow_gap_reg  <= 12'h000;
         slow_seen_reg <= 1'b0;
      end else if (slow_lvl_next != slow_lvl_reg) begin
         slow_gap_reg  <= 12'h000;
         slow_seen_reg <= 1'b1;
      end else
         slow_gap_reg <= slow_gap_reg + 12'h001;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence fast_edge_s;
      fast_run_reg && $changed(fast_clk_reg);
   endsequence
   sequence fast_gap_s;
      $stable(fast_clk_reg) [*2] ##[1:2] $changed(fast_clk_reg);
   endsequence
   a_fast_half_period: assert property (
      disable iff (!rst_n || !fast_run_reg) fast_edge_s |=> fast_gap_s)
      else $error("fast clock half period out of range");
   a_slow_half_period: assert property (
      (slow_lvl_next != slow_lvl_reg) && slow_seen_reg |->
         (32'(slow_gap_reg) + 1 >= clk_sel_pkg::SLOW_HALF_CYC) &&
         (32'(slow_gap_reg) <= clk_sel_pkg::SLOW_HALF_CYC))
      else $error("slow clock half period out of range");
   a_wdt_alive: assert property (
      slow_gap_reg <= 12'(clk_sel_pkg::SLOW_HALF_CYC))
      else $error("watchdog clock stalled");
   a_div_on_rise: assert property (
      $changed(div_cnt_reg[0]) && $past(fast_run_reg) && fast_run_reg |-> $rose(fast_clk_reg))
      else $error("divider stepped without a fast rising edge");
   a_sub_select: assert property (
      active_sel_reg == clk_sel_pkg::SEL_SUB && $stable(active_sel_reg)
         |=> sys_clk_reg == $past(sub_clk_reg))
      else $error("code 111 does not route the sub clock");
   a_reset_select: assert property (
      disable iff (1'b0) !rst_n |=> sel_reg == 3'h1 && active_sel_reg == 3'h1)
      else $error("selection not 001 after reset");
   sequence new_code_s;
      $changed(sel_reg) && sel_reg != active_sel_reg;
   endsequence
   a_switch_pending: assert property (
      new_code_s ##1 (sel_reg != active_sel_reg) |-> pending_w)
      else $error("pending flag missing during a switch");
   a_no_runt: assert property (
      $changed(active_sel_reg) |->
         !sys_clk_reg && ((($past(src_w) >> active_sel_reg) & 8'h01) == 8'h00))
      else $error("switch taken while a source was high");
   a_fast_kept: assert property (
      !cpu_halt && active_sel_reg == clk_sel_pkg::SEL_SUB && sel_reg == clk_sel_pkg::SEL_SUB
         |=> fast_run_reg == $past(fast_osc_en_reg))
      else $error("fast oscillator ignores its enable under the sub clock");
   a_idle_stop: assert property (
      cpu_halt |=> fast_run_reg == $past(fast_idle_en_reg) &&
                   sub_run_reg == $past(slow_idle_en_reg))
      else $error("oscillator state during halt ignores idle enables");
endmodule : system_clock_select

// file: test/test_system_clock_select.sv
// self-checking bench for the system clock selector, driven over its register bus
`timescale 1ns/10ps
module test_system_clock_select;
   localparam int TMO = 20000;
   logic                   clock;
   logic                   rst_n;
   clk_sel_pkg::axi_req_t  axi_req;
   clk_sel_pkg::axi_resp_t axi_resp;
   logic                   cpu_halt;
   logic                   sys_clk;
   logic                   fast_clk;
   logic [6:0]             periph_div_clk;
   logic                   sub_clk;
   logic                   wdt_clk;
   int                     mismatches = 0;
   int                     checks_done = 0;
   int                     glitches = 0;
   int                     run_len = 0;
   logic                   run_lvl = 1'b0;
   logic                   run_seen = 1'b0;
   logic [31:0]            rd;
   logic [1:0]             rsp;
   int                     n_sys, n_fast, n_div, n_sub, n_wdt;

   system_clock_select i_system_clock_select (
      .clock(clock), .rst_n(rst_n), .axi_req(axi_req), .axi_resp(axi_resp),
      .cpu_halt(cpu_halt), .sys_clk(sys_clk), .fast_clk(fast_clk),
      .periph_div_clk(periph_div_clk), .sub_clk(sub_clk), .wdt_clk(wdt_clk));

   // 125 MHz clock
   initial clock = 1'b0;
   always #4 clock = ~clock;

   // level runs shorter than a fast half period mean a truncated sys_clk pulse
   always @(posedge clock) begin
      if (!rst_n) begin
         run_len <= 0;
      end else if (sys_clk !== run_lvl) begin
         if (run_seen && run_len < int'(clk_sel_pkg::FAST_HALF_CYC)) glitches <= glitches + 1;
         run_seen <= 1'b1;
         run_lvl  <= sys_clk;
         run_len  <= 1;
      end else begin
         run_len <= run_len + 1;
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic timed_out(input string what);
      mismatches++;
      $display("mismatch %s expected answer seen timeout", what);
      stop_test();
   endtask : timed_out

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   // rising-edge counts drift by one with the oscillator start phase
   task automatic check_near(input string name, input int exp, input int got);
      checks_done++;
      if (got > exp + 1 || got < exp - 1) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask : check_near

   task automatic axi_write(input logic [11:0] ofs, input logic [31:0] data,
                            input logic [3:0] strb, output logic [1:0] resp);
      int   i;
      logic aw_ok;
      logic w_ok;
      @(posedge clock);
      axi_req.awaddr  <= {20'h00000, ofs};
      axi_req.wdata   <= data;
      axi_req.wstrb   <= strb;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid  <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      for (i = 0; i < TMO && !(aw_ok && w_ok); i++) begin
         @(posedge clock);
         if (!aw_ok && axi_resp.awready === 1'b1) begin
            aw_ok = 1'b1;
            axi_req.awvalid <= 1'b0;
         end
         if (!w_ok && axi_resp.wready === 1'b1) begin
            w_ok = 1'b1;
            axi_req.wvalid <= 1'b0;
         end
      end
      if (i >= TMO) timed_out("write address or data");
      axi_req.bready <= 1'b1;
      for (i = 0; i < TMO && axi_resp.bvalid !== 1'b1; i++) @(posedge clock);
      if (i >= TMO) timed_out("write response");
      resp = axi_resp.bresp;
      axi_req.bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] ofs, output logic [31:0] data,
                           output logic [1:0] resp);
      int i;
      @(posedge clock);
      axi_req.araddr  <= {20'h00000, ofs};
      axi_req.arvalid <= 1'b1;
      // hold the request until arready is seen high at an edge
      for (i = 0; i < TMO; i++) begin
         @(posedge clock);
         if (axi_resp.arready === 1'b1) break;
      end
      if (i >= TMO) timed_out("read address");
      axi_req.arvalid <= 1'b0;
      axi_req.rready  <= 1'b1;
      for (i = 0; i < TMO && axi_resp.rvalid !== 1'b1; i++) @(posedge clock);
      if (i >= TMO) timed_out("read data");
      data = axi_resp.rdata;
      resp = axi_resp.rresp;
      axi_req.rready <= 1'b0;
   endtask : axi_read

   // counts rising edges of sys, fast, sub and watchdog clocks and of divider output k over n cycles, after a short settle
   task automatic measure(input int n, input int k);
      logic [4:0] prev;
      logic [4:0] now;
      n_sys = 0; n_fast = 0; n_div = 0; n_sub = 0; n_wdt = 0;
      repeat (8) @(posedge clock);
      prev = {sys_clk, fast_clk, periph_div_clk[k], sub_clk, wdt_clk};
      repeat (n) begin
         @(posedge clock);
         now = {sys_clk, fast_clk, periph_div_clk[k], sub_clk, wdt_clk};
         n_sys  += int'(now[4] & !prev[4]);
         n_fast += int'(now[3] & !prev[3]);
         n_div  += int'(now[2] & !prev[2]);
         n_sub  += int'(now[1] & !prev[1]);
         n_wdt  += int'(now[0] & !prev[0]);
         prev = now;
      end
   endtask : measure

   function automatic int rises(input int n, input longint hz);
      return int'(longint'(n) * hz / longint'(clk_sel_pkg::CLOCK_HZ));
   endfunction : rises

   task automatic wait_switch();
      int i;
      for (i = 0; i < 5000; i++) begin
         axi_read(clk_sel_pkg::STATUS_OFS, rd, rsp);
         if (rd[clk_sel_pkg::ST_PEND_BIT] === 1'b0) break;
      end
      if (i >= 5000) timed_out("switch pending");
   endtask : wait_switch

   task automatic test_reset();
      axi_read(clk_sel_pkg::CLOCK_CTRL_OFS, rd, rsp);
      check("ctrl reset", 32'(clk_sel_pkg::SEL_RESET) << clk_sel_pkg::SEL_LSB, rd);
      axi_read(clk_sel_pkg::FAST_OSC_OFS, rd, rsp);
      check("fast enable reset", 32'h00000001, 32'(rd[clk_sel_pkg::FAST_EN_BIT]));
      axi_read(clk_sel_pkg::STATUS_OFS, rd, rsp);
      check("active sel reset", 32'(clk_sel_pkg::SEL_RESET), 32'(rd[2:0]));
      axi_read(12'h00C, rd, rsp);
      check("unmapped resp", 32'(clk_sel_pkg::RESP_SLVERR), 32'(rsp));
      check("unmapped data", 32'h00000000, rd);
      axi_write(clk_sel_pkg::CLOCK_CTRL_OFS, 32'h000000E3, 4'h0, rsp);
      axi_write(clk_sel_pkg::STATUS_OFS, 32'h0000001F, 4'hF, rsp);
      check("status write resp", 32'(clk_sel_pkg::RESP_OKAY), 32'(rsp));
      axi_read(clk_sel_pkg::CLOCK_CTRL_OFS, rd, rsp);
      check("ctrl after masked write", 32'h00000020, rd);
      $display("test reset done");
   endtask : test_reset

   task automatic test_select();
      int i;
      for (int k = 0; k < 7; k++) begin
         axi_write(clk_sel_pkg::CLOCK_CTRL_OFS, 32'(k) << clk_sel_pkg::SEL_LSB, 4'hF, rsp);
         wait_switch();
         check("active sel", 32'(k), 32'(rd[2:0]));
         measure(4000, k);
         check_near("sys rises", rises(4000, clk_sel_pkg::FAST_OSC_HZ) >> k, n_sys);
         check_near("div rises", rises(4000, clk_sel_pkg::FAST_OSC_HZ) >> k, n_div);
         check_near("fast rises", rises(4000, clk_sel_pkg::FAST_OSC_HZ), n_fast);
      end
      // write just after a sub rise, so the switch must wait out the high phase
      for (i = 0; i < 5000 && sub_clk !== 1'b0; i++) @(posedge clock);
      if (i >= 5000) timed_out("sub clock low");
      for (i = 0; i < 5000 && sub_clk !== 1'b1; i++) @(posedge clock);
      if (i >= 5000) timed_out("sub clock high");
      axi_write(clk_sel_pkg::CLOCK_CTRL_OFS, 32'h000000E0, 4'hF, rsp);
      axi_read(clk_sel_pkg::STATUS_OFS, rd, rsp);
      check("pending after write", 32'h00000001, 32'(rd[clk_sel_pkg::ST_PEND_BIT]));
      check("old source kept", 32'h00000006, 32'(rd[2:0]));
      wait_switch();
      check("active sub", 32'(clk_sel_pkg::SEL_SUB), 32'(rd[2:0]));
      measure(8000, 6);
      check_near("sys on sub", rises(8000, clk_sel_pkg::SLOW_OSC_HZ), n_sys);
      check_near("sub rises", rises(8000, clk_sel_pkg::SLOW_OSC_HZ), n_sub);
      $display("test select done");
   endtask : test_select

   task automatic test_fast_stop();
      axi_write(clk_sel_pkg::FAST_OSC_OFS, 32'h00000000, 4'hF, rsp);
      measure(2000, 6);
      check("fast stopped", 32'h00000000, 32'(n_fast));
      check("dividers stopped", 32'h00000000, 32'(n_div));
      axi_read(clk_sel_pkg::FAST_OSC_OFS, rd, rsp);
      check("fast off not ready", 32'h00000000, rd);
      axi_write(clk_sel_pkg::FAST_OSC_OFS, 32'h00000001, 4'hF, rsp);
      measure(2000, 6);
      check_near("fast restarted", rises(2000, clk_sel_pkg::FAST_OSC_HZ), n_fast);
      axi_read(clk_sel_pkg::FAST_OSC_OFS, rd, rsp);
      check("fast on and ready", 32'h00000003, rd);
      $display("test fast stop done");
   endtask : test_fast_stop

   task automatic test_halt();
      for (int v = 0; v < 4; v++) begin
         axi_write(clk_sel_pkg::CLOCK_CTRL_OFS, 32'h000000E0 | 32'(v), 4'hF, rsp);
         cpu_halt <= 1'b1;
         measure(4000, 0);
         check("fast in halt", 32'(v >> 1), 32'(n_fast != 0));
         check("sub in halt", 32'(v & 1), 32'(n_sub != 0));
         check("watchdog clock", 32'h00000001, 32'(n_wdt != 0));
         cpu_halt <= 1'b0;
      end
      axi_write(clk_sel_pkg::CLOCK_CTRL_OFS, 32'h00000020, 4'hF, rsp);
      wait_switch();
      check("glitches", 32'h00000000, 32'(glitches));
      $display("test halt done");
   endtask : test_halt

   // reset, then the scenarios in order
   initial begin
      axi_req  = '0;
      cpu_halt = 1'b0;
      rst_n    = 1'b0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      test_reset();
      test_select();
      test_fast_stop();
      test_halt();
      stop_test();
   end
endmodule : test_system_clock_select
